// file: core/dcs_sched_table.sv
// Programmable credit schedule table for the packet DMA controller
`include "dcs_map.svh"
`default_nettype none

module dcs_sched_table
#(
  parameter int NUM_RX_FIFO = 4,
  parameter int TABLE_WORDS = `DCS_TABLE_WORDS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB register bus
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Credit to the DMA controller
  output logic creditValid,
  input wire logic creditReady,
  output dcs_pkg::dcs_dir_t creditDir,
  output logic [3:0] creditChan,
  output logic [$clog2(NUM_RX_FIFO)-1:0] creditRxFifo,
  // Receive FIFO head state from the DMA controller
  input wire logic [NUM_RX_FIFO*4-1:0] rxHeadChan,
  input wire logic [NUM_RX_FIFO-1:0] rxFifoShared
);
  import dcs_pkg::*;

  localparam int FB = $clog2(NUM_RX_FIFO);
  localparam int WB = $clog2(TABLE_WORDS);

  // ==========================================
  // Bus front end
  dcs_reg_if regs ();

  dcs_apb_front u_front
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .regs(regs)
  );

  // ==========================================
  // Address decode
  function automatic logic inBank(input logic [11:0] a, input logic [11:0] base);
    inBank = ((a & `DCS_OFS_BANK_MASK) == base) && (a[1:0] == 2'b00)
      && (int'(a[7:2]) < TABLE_WORDS);
  endfunction

  logic selLast;
  logic selEnable;
  logic selStatus;
  logic selLow;
  logic selHigh;
  logic [WB-1:0] wordSel;

  assign selLast = regs.addr == `DCS_OFS_LAST_ENTRY;
  assign selEnable = regs.addr == `DCS_OFS_ENABLE;
  assign selStatus = regs.addr == `DCS_OFS_STATUS;
  assign selLow = inBank(regs.addr, `DCS_OFS_LOW_BASE);
  assign selHigh = inBank(regs.addr, `DCS_OFS_HIGH_BASE);
  assign wordSel = regs.addr[WB+1:2];

  // Reserved bits of each slot never stored, so the scheduler reads them as zero
  function automatic logic [15:0] stripPair(input logic [31:0] d);
    stripPair = {d[15:8] & ~`DCS_SLOT_RSVD_MASK, d[7:0] & ~`DCS_SLOT_RSVD_MASK};
  endfunction

  // ==========================================
  // Control registers
  logic [`DCS_LAST_ENTRY_MSB:0] lastEntryReg;
  logic [`DCS_LAST_ENTRY_MSB:0] lastEntryNext;
  logic enableReg;
  logic enableNext;

  always_comb
  begin
    lastEntryNext = lastEntryReg;
    enableNext = enableReg;
    if (regs.wrStb && selLast)
    begin
      lastEntryNext = regs.wdata[`DCS_LAST_ENTRY_MSB:0];
    end
    if (regs.wrStb && selEnable)
    begin
      enableNext = regs.wdata[`DCS_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lastEntryReg <= `DCS_RST_LAST_ENTRY;
      enableReg <= 1'b0;
    end
    else
    begin
      lastEntryReg <= lastEntryNext;
      enableReg <= enableNext;
    end
  end

  // ==========================================
  // Table storage
  logic [15:0] lowMem [TABLE_WORDS];
  logic [15:0] highMem [TABLE_WORDS];
  logic lowWe;
  logic highWe;
  logic [15:0] pairNext;

  always_comb
  begin
    lowWe = regs.wrStb && selLow;
    highWe = regs.wrStb && selHigh;
    pairNext = stripPair(regs.wdata);
  end

  // Whole table clears on reset, so an early enable credits channel 0 only
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < TABLE_WORDS; i++)
      begin
        lowMem[i] <= `DCS_RST_WORD;
        highMem[i] <= `DCS_RST_WORD;
      end
    end
    else
    begin
      if (lowWe)
      begin
        lowMem[wordSel] <= pairNext;
      end
      if (highWe)
      begin
        highMem[wordSel] <= pairNext;
      end
    end
  end

  // ==========================================
  // Scheduler
  dcs_state_t stateReg;
  dcs_state_t stateNext;
  logic [7:0] idxReg;
  logic [7:0] idxNext;
  logic validReg;
  logic validNext;
  dcs_dir_t dirReg;
  dcs_dir_t dirNext;
  logic [3:0] chanReg;
  logic [3:0] chanNext;
  logic [FB-1:0] fifoReg;
  logic [FB-1:0] fifoNext;
  logic [15:0] pairRead;
  dcs_entry_t entryRaw;
  dcs_dir_t decDir;
  logic [3:0] decChan;
  logic [FB-1:0] decFifo;

  // Entry e lives in word e/4; slots 0,1 in the low pair, 2,3 in the high
  assign pairRead = idxReg[1] ? highMem[idxReg[WB+1:2]] : lowMem[idxReg[WB+1:2]];
  assign entryRaw = idxReg[0] ? pairRead[15:8] : pairRead[7:0];

  dcs_entry_decode #(.NUM_RX_FIFO(NUM_RX_FIFO)) u_decode
  (
    .entry(entryRaw),
    .rxHeadChan(rxHeadChan),
    .rxFifoShared(rxFifoShared),
    .dir(decDir),
    .chan(decChan),
    .rxFifo(decFifo)
  );

  always_comb
  begin
    stateNext = stateReg;
    idxNext = idxReg;
    validNext = validReg;
    dirNext = dirReg;
    chanNext = chanReg;
    fifoNext = fifoReg;
    unique case (stateReg)
      DCS_IDLE:
      begin
        idxNext = 8'h00;
        if (enableReg)
        begin
          stateNext = DCS_FETCH;
        end
      end
      DCS_FETCH:
      begin
        if (!enableReg)
        begin
          stateNext = DCS_IDLE;
        end
        else
        begin
          dirNext = decDir;
          chanNext = decChan;
          fifoNext = decFifo;
          validNext = 1'b1;
          stateNext = DCS_OFFER;
        end
      end
      DCS_OFFER:
      begin
        if (!enableReg)
        begin
          // Withdrawn credit is not passed once disabled
          validNext = 1'b0;
          stateNext = DCS_IDLE;
        end
        else if (creditReady)
        begin
          validNext = 1'b0;
          stateNext = DCS_FETCH;
          idxNext = (idxReg >= lastEntryReg) ? 8'h00 : 8'(idxReg + 8'h01);
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stateReg <= DCS_IDLE;
      idxReg <= 8'h00;
      validReg <= 1'b0;
      dirReg <= DCS_DIR_TX;
      chanReg <= 4'h0;
      fifoReg <= '0;
    end
    else
    begin
      stateReg <= stateNext;
      idxReg <= idxNext;
      validReg <= validNext;
      dirReg <= dirNext;
      chanReg <= chanNext;
      fifoReg <= fifoNext;
    end
  end

  assign creditValid = validReg;
  assign creditDir = dirReg;
  assign creditChan = chanReg;
  assign creditRxFifo = fifoReg;

  // ==========================================
  // Read data
  always_comb
  begin
    regs.rdata = 32'h00000000;
    regs.err = !(selLast || selEnable || selStatus || selLow || selHigh);
    if (selLast)
    begin
      regs.rdata[`DCS_LAST_ENTRY_MSB:0] = lastEntryReg;
    end
    else if (selEnable)
    begin
      regs.rdata[`DCS_ENABLE_BIT] = enableReg;
    end
    else if (selStatus)
    begin
      regs.rdata[`DCS_STAT_IDX_LSB +: 8] = idxReg;
      regs.rdata[`DCS_STAT_RUN_BIT] = stateReg != DCS_IDLE;
      regs.rdata[`DCS_STAT_BUSY_BIT] = validReg;
    end
    // Table words are write-only and read as zero
  end
endmodule

`default_nettype wire

// file: pkg/dcs_map.svh
// Register offsets, field positions, reset values and sizes of the credit schedule table
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH

// ==========================================
// Byte offsets on the register bus
`define DCS_OFS_LAST_ENTRY 12'h000
`define DCS_OFS_ENABLE 12'h004
`define DCS_OFS_STATUS 12'h008
`define DCS_OFS_LOW_BASE 12'h100
`define DCS_OFS_HIGH_BASE 12'h200
`define DCS_OFS_BANK_MASK 12'hF00

// ==========================================
// Field positions
`define DCS_LAST_ENTRY_MSB 7
`define DCS_ENABLE_BIT 15
`define DCS_SLOT_DIR_BIT 7
`define DCS_SLOT_CHAN_MSB 3
`define DCS_SLOT_RSVD_MASK 8'h70
`define DCS_STAT_IDX_LSB 0
`define DCS_STAT_RUN_BIT 8
`define DCS_STAT_BUSY_BIT 9

// ==========================================
// Reset values and sizes
`define DCS_RST_WORD 16'h0000
`define DCS_RST_LAST_ENTRY 8'h00
`define DCS_TABLE_WORDS 64
`define DCS_CHAN_COUNT 16

`endif

// file: pkg/dcs_pkg.sv
// Types shared by the credit schedule table modules
`default_nettype none

package dcs_pkg;

  typedef enum logic
  {
    DCS_DIR_TX = 1'b0,
    DCS_DIR_RX = 1'b1
  } dcs_dir_t;

  typedef struct packed
  {
    dcs_dir_t dir;
    logic [2:0] rsvd;
    logic [3:0] chan;
  } dcs_entry_t;

  typedef enum
  {
    DCS_IDLE,
    DCS_FETCH,
    DCS_OFFER
  } dcs_state_t;

endpackage

`default_nettype wire

// file: pkg/dcs_reg_if.sv
// Register access carrier between the bus front end and the table core
`default_nettype none

interface dcs_reg_if;
  logic wrStb;
  logic rdStb;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic err;

  modport front
  (
    output wrStb,
    output rdStb,
    output addr,
    output wdata,
    input rdata,
    input err
  );

  modport core
  (
    input wrStb,
    input rdStb,
    input addr,
    input wdata,
    output rdata,
    output err
  );
endinterface

`default_nettype wire

// file: core/dcs_apb_front.sv
// APB slave front end with one wait state and registered answers
`default_nettype none

module dcs_apb_front
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave side
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side
  dcs_reg_if.front regs
);
  import dcs_pkg::*;

  logic readyReg;
  logic readyNext;
  logic [31:0] rdataReg;
  logic [31:0] rdataNext;
  logic errReg;
  logic errNext;
  logic firstAccess;

  // ==========================================
  // Decode
  // Answer is prepared in the first access cycle, so prdata is a flop
  assign firstAccess = psel && penable && !readyReg;
  // Writes commit only at the edge where the master sees pready
  assign regs.wrStb = psel && penable && readyReg && pwrite && !errReg;
  assign regs.rdStb = firstAccess && !pwrite;
  assign regs.addr = paddr;
  assign regs.wdata = pwdata;

  always_comb
  begin
    readyNext = 1'b0;
    rdataNext = rdataReg;
    // Error stands only beside pready, never between transfers
    errNext = 1'b0;
    if (firstAccess)
    begin
      readyNext = 1'b1;
      rdataNext = pwrite ? 32'h00000000 : regs.rdata;
      errNext = regs.err;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      readyReg <= 1'b0;
      rdataReg <= 32'h00000000;
      errReg <= 1'b0;
    end
    else
    begin
      readyReg <= readyNext;
      rdataReg <= rdataNext;
      errReg <= errNext;
    end
  end

  assign pready = readyReg;
  assign prdata = rdataReg;
  assign pslverr = errReg;
endmodule

`default_nettype wire

// file: core/dcs_entry_decode.sv
// Splits a table entry and resolves the channel named in its credit
`default_nettype none

module dcs_entry_decode
#(
  parameter int NUM_RX_FIFO = 4
)
(
  // Raw entry
  input wire dcs_pkg::dcs_entry_t entry,
  // Receive FIFO heads
  input wire logic [NUM_RX_FIFO*4-1:0] rxHeadChan,
  input wire logic [NUM_RX_FIFO-1:0] rxFifoShared,
  // Resolved credit
  output dcs_pkg::dcs_dir_t dir,
  output logic [3:0] chan,
  output logic [$clog2(NUM_RX_FIFO)-1:0] rxFifo
);
  import dcs_pkg::*;

  localparam int FB = $clog2(NUM_RX_FIFO);

  logic [3:0] headChan;

  // Channel n is tied to FIFO n modulo the FIFO count
  assign rxFifo = entry.chan[FB-1:0];
  assign headChan = rxHeadChan[rxFifo*4 +: 4];
  assign dir = entry.dir;

  always_comb
  begin
    chan = entry.chan;
    // Shared FIFO credits whichever channel sits at its head
    if (entry.dir == DCS_DIR_RX && rxFifoShared[rxFifo])
    begin
      chan = headChan;
    end
  end
endmodule

`default_nettype wire

// file: verification/dcs_sched_table_props.sv
// Port checker for the credit schedule table
`default_nettype none

module dcs_sched_table_props
#(
  parameter int NUM_RX_FIFO = 4
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register bus
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Credit side
  input wire logic creditValid,
  input wire logic creditReady,
  input wire dcs_pkg::dcs_dir_t creditDir,
  input wire logic [3:0] creditChan,
  input wire logic [$clog2(NUM_RX_FIFO)-1:0] creditRxFifo,
  input wire logic [NUM_RX_FIFO*4-1:0] rxHeadChan,
  input wire logic [NUM_RX_FIFO-1:0] rxFifoShared
);
  timeunit 1ns;
  timeprecision 1ps;
  import dcs_pkg::*;
  logic enWr;
  logic rxCred;
  assign enWr = psel && penable && pready && pwrite && paddr == 12'h004;
  assign rxCred = creditValid && creditDir == DCS_DIR_RX;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Register bus
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("wait state count wrong");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_wo_zero: assert property (
    pready && !pwrite && paddr[11:8] != 4'h0 |-> prdata == 32'h0)
    else $error("table word read not zero");
  // ==========================================
  // Credits
  a_credit_hold: assert property (creditValid && !creditReady |=>
    !creditValid || $stable({creditDir, creditChan, creditRxFifo}))
    else $error("credit changed before accept");
  a_accept_gap: assert property (creditValid && creditReady |=> !creditValid)
    else $error("no fetch after accept");
  a_stop_drop: assert property (enWr && !pwdata[15] |-> ##[1:2] !creditValid)
    else $error("credit kept after disable");
  a_start_credit: assert property (enWr && pwdata[15] && !creditValid |->
    ##[2:3] creditValid)
    else $error("no credit after enable");
  a_shared_head: assert property (rxCred && rxFifoShared[creditRxFifo] |->
    creditChan == rxHeadChan[creditRxFifo*4 +: 4])
    else $error("shared fifo credit not head channel");
  a_rx_fifo: assert property (rxCred && !rxFifoShared[creditRxFifo] |->
    creditRxFifo == creditChan[$clog2(NUM_RX_FIFO)-1:0])
    else $error("receive credit on wrong fifo");
endmodule

bind dcs_sched_table dcs_sched_table_props #(.NUM_RX_FIFO(NUM_RX_FIFO)) props_u
(
  .clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .creditValid(creditValid), .creditReady(creditReady), .creditDir(creditDir),
  .creditChan(creditChan), .creditRxFifo(creditRxFifo), .rxHeadChan(rxHeadChan),
  .rxFifoShared(rxFifoShared)
);

`default_nettype wire

// file: verification/dcs_dma_model.sv
// Behavioural DMA controller that takes credits and shows fifo heads
`default_nettype none

module dcs_dma_model
#(
  parameter int NUM_RX_FIFO = 4,
  parameter logic [NUM_RX_FIFO*4-1:0] HEADS = 16'h1E23,
  parameter logic [NUM_RX_FIFO-1:0] SHARED = 4'h4
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Slow answer while high
  input wire logic stall,
  // Credit handshake
  input wire logic creditValid,
  output logic creditReady,
  output logic [NUM_RX_FIFO*4-1:0] rxHeadChan,
  output logic [NUM_RX_FIFO-1:0] rxFifoShared
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ready only for a credit on offer, dropped after each take
  always_ff @(posedge clk)
    creditReady <= !sys_rst && creditValid && !creditReady && !stall;
  // Heads held still so a sampled head stays the expected one
  assign rxHeadChan = HEADS;
  assign rxFifoShared = SHARED;
endmodule

`default_nettype wire

// file: verification/dcs_sched_table_tb_top.sv
// Self-checking bench for the credit schedule table
`default_nettype none

module dcs_sched_table_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dcs_pkg::*;
  localparam logic [15:0] HEAD = 16'h1E23;
  localparam logic [3:0] SHARED = 4'h4;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic stall = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, creditValid, creditReady;
  dcs_dir_t creditDir;
  logic [3:0] creditChan;
  logic [1:0] creditRxFifo;
  logic [15:0] rxHeadChan;
  logic [3:0] rxFifoShared;
  logic [2:0] cyc = 3'h0;
  logic [7:0] got[$];
  logic [7:0] ent[0:7] = '{8'h7F, 8'h85, 8'h00, 8'hCA, 8'h09, 8'h83, 8'hFF, 8'hFF};
  int fail_count = 0;
  int n_checks = 0;

  dcs_sched_table #(.NUM_RX_FIFO(4)) dut_u
  (
    .clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .creditValid(creditValid), .creditReady(creditReady), .creditDir(creditDir),
    .creditChan(creditChan), .creditRxFifo(creditRxFifo), .rxHeadChan(rxHeadChan),
    .rxFifoShared(rxFifoShared)
  );
  dcs_dma_model #(.NUM_RX_FIFO(4), .HEADS(HEAD), .SHARED(SHARED)) model_u
  (
    .clk(clk), .sys_rst(sys_rst), .stall(stall), .creditValid(creditValid),
    .creditReady(creditReady), .rxHeadChan(rxHeadChan), .rxFifoShared(rxFifoShared)
  );

  initial
  begin
    forever #20 clk = ~clk;
  end
  // Far side stalls half the time
  always @(posedge clk)
  begin
    cyc <= cyc + 3'h1;
    stall <= cyc[2];
    if (creditValid && creditReady)
      got.push_back({creditDir, 1'b0, creditDir ? creditRxFifo : 2'h0, creditChan});
  end

  // ==========================================
  // Report and compare
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check32(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %0t reg got %h exp %h", $time, g, e);
      fail_count++;
    end
  endtask
  task automatic checkCred(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %0t credit got %h exp %h", $time, g, e);
      fail_count++;
    end
  endtask
  task automatic timeout(input int n);
    if (n >= 2000)
    begin
      $display("[FAIL] %0t wait ran out", $time);
      fail_count++;
      tally_and_finish();
    end
  endtask

  // ==========================================
  // APB master
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 2000);
    timeout(n);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    check32(r, x);
    check32({31'h0, e}, {31'h0, xe});
  endtask

  // Entry as credited: reserved bits gone, receive fifo in 5..4, shared fifo shows its head
  function automatic logic [7:0] expEntry(input int e);
    logic [7:0] b;
    logic [1:0] f;
    b = ent[e];
    f = b[7] ? b[1:0] : 2'h0;
    return {b[7], 1'b0, f, (b[7] && SHARED[b[1:0]]) ? HEAD[b[1:0]*4 +: 4] : b[3:0]};
  endfunction

  task automatic runCredits(input logic [7:0] last, input int cnt);
    int n;
    wr(12'h000, {24'h0, last});
    rdChk(12'h000, {24'h0, last}, 1'b0);
    got.delete();
    wr(12'h004, 32'h8000);
    for (n = 0; n < 2000 && got.size() < cnt; n++)
      @(posedge clk);
    timeout(n);
    wr(12'h004, 32'h0);
    for (int i = 0; i < cnt; i++)
      checkCred(got[i], expEntry(i % (last + 1)));
    rdChk(12'h008, 32'h0, 1'b0);
    check32({31'h0, creditValid}, 32'h0);
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rdChk(12'h008, 32'h0, 1'b0);
    rdChk(12'h000, 32'h0, 1'b0);
    rdChk(12'h100, 32'h0, 1'b0);
    rdChk(12'h00C, 32'h0, 1'b1);
    rdChk(12'h101, 32'h0, 1'b1);
    for (int w = 0; w < 2; w++)
    begin
      wr(12'h100 + 12'(4 * w), {16'h0, ent[4 * w + 1], ent[4 * w]});
      wr(12'h200 + 12'(4 * w), {16'h0, ent[4 * w + 3], ent[4 * w + 2]});
    end
    rdChk(12'h204, 32'h0, 1'b0);
    runCredits(8'h05, 14);
    runCredits(8'h00, 3);
    tally_and_finish();
  end
endmodule

`default_nettype wire
